/* ppi_defines.vh */
// constants of the parallel programming port: pin codes, commands, reset values, times
// assumes inclusion by ppi_top.v and the testbench; ppi_sync.v does not include it
`ifndef PPI_DEFINES_VH
`define PPI_DEFINES_VH

// action codes sampled on a load_clock rising edge
`define PPI_ACT_ADDR        2'h0
`define PPI_ACT_DATA        2'h1
`define PPI_ACT_CMD         2'h2
`define PPI_ACT_IDLE        2'h3

// command bytes
`define PPI_CMD_NOP         8'h00
`define PPI_CMD_CHIP_ERASE  8'h80
`define PPI_CMD_WR_FUSE     8'h40
`define PPI_CMD_WR_LOCK     8'h20
`define PPI_CMD_WR_FLASH    8'h10
`define PPI_CMD_WR_EEPROM   8'h11
`define PPI_CMD_RD_SIG      8'h08
`define PPI_CMD_RD_FUSE     8'h04
`define PPI_CMD_RD_FLASH    8'h02
`define PPI_CMD_RD_EEPROM   8'h03

// byte-select pair {byte_select_hi, byte_select_lo}
`define PPI_BS_LOW          2'h0
`define PPI_BS_HIGH         2'h1
`define PPI_BS_EXT          2'h2
`define PPI_BS_RSVD         2'h3

// fuse and lock reset values, keep_eeprom_fuse position in the fuse high byte
`define PPI_FUSE_LOW_RST    8'h5e
`define PPI_FUSE_HIGH_RST   8'h99
`define PPI_FUSE_EXT_RST    8'hf3
`define PPI_LOCK_RST        8'hff
`define PPI_KEEP_EE_BIT     3

// geometry
`define PPI_FLASH_AW        16
`define PPI_FLASH_PAGE_AW   7
`define PPI_EE_AW           12
`define PPI_EE_PAGE_AW      3

// times
`define PPI_CLK_PERIOD_NS   50
`define PPI_ENTRY_HOLD_NS   100
`define PPI_ENTRY_TOGGLES   6
`define PPI_NV_WRITE_CYC    200

`endif

/* ppi_sync.v */
// two-flop synchroniser for the programming pins
// assumes inputs are asynchronous to clk
`timescale 1ns/10ps
module ppi_sync #(
  parameter W = 17
) (
  // clock and reset
  input  wire         clk,
  input  wire         reset,
  // pins
  input  wire [W-1:0] async_in,
  // synchronised level
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always @(posedge clk) begin
    if (reset) begin
      meta_reg <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // ppi_sync

/* ppi_top.v */
// parallel programming port: command/address/data loading, page buffers,
// erase and page write sequencer, readback onto the data bus
// assumes pins arrive asynchronously and the high-voltage reset is seen as a level
`timescale 1ns/10ps
`include "ppi_defines.vh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RULE_01 - programmer pulses last at least 250 ns
// RULE_02 - load_clock edge decodes action code bits
// RULE_03 - strobes execute most recent loaded command
// RULE_04 - ten command bytes decoded as listed
// RULE_05 - byte select picks address low/high/extended
// RULE_06 - byte_select_lo picks flash data byte
// RULE_07 - byte select picks fuse/lock read byte
// RULE_08 - ready_busy_n low while programming or erasing
// RULE_09 - data bus driven only while output_enable_n low
// RULE_10 - entry pattern 0000 held around high voltage
// RULE_11 - six load_clock toggles before entry
// RULE_12 - wait settling time before first command
// RULE_13 - command and address persist across operations
// RULE_14 - reload high byte only per window
// RULE_15 - erase clears memories then locks, keeps fuses
// RULE_16 - keep_eeprom_fuse programmed preserves eeprom on erase
// RULE_17 - write strobe starts erase, busy until done
// RULE_18 - page_load_strobe latches data word into buffer
// RULE_19 - 128-word flash page, low bits index word
// RULE_20 - address low byte top bits address page
// RULE_21 - 8-byte eeprom page, bits 2..0 index byte
// RULE_22 - erase before reprogramming, skip 0xff
// RULE_23 - write strobe with select 00 writes page
// RULE_24 - no-operation command clears write state
// RULE_25 - flash read gives low/high byte by select
// RULE_26 - pins sampled on load_clock rising edge
module ppi_top #(
  parameter FLASH_AW    = `PPI_FLASH_AW,
  parameter PAGE_AW     = `PPI_FLASH_PAGE_AW,
  parameter EE_AW       = `PPI_EE_AW,
  parameter EE_PAGE_AW  = `PPI_EE_PAGE_AW,
  parameter NV_WRITE_CYC = `PPI_NV_WRITE_CYC,
  parameter [7:0] SIG_BYTE0 = 8'h01, // arbitrary identity value
  parameter [7:0] SIG_BYTE1 = 8'h02, // arbitrary identity value
  parameter [7:0] SIG_BYTE2 = 8'h03, // arbitrary identity value
  parameter [7:0] CAL_BYTE  = 8'h80  // arbitrary calibration value
) (
  // clock and reset
  input  wire       clk,
  input  wire       reset,
  // programming pins
  input  wire       hv_reset_detect,
  input  wire       load_clock,
  input  wire       action_code_bit1,
  input  wire       action_code_bit0,
  input  wire       byte_select_hi,
  input  wire       byte_select_lo,
  input  wire       page_load_strobe,
  input  wire       program_strobe_n,
  input  wire       output_enable_n,
  // data bus, three signals
  input  wire [7:0] data_in,
  output reg  [7:0] data_out,
  output reg        data_oe,
  // status
  output reg        ready_busy_n,
  output reg        prog_mode_active
);
  localparam FLASH_WORDS = 1 << FLASH_AW;
  localparam PAGE_WORDS  = 1 << PAGE_AW;
  localparam EE_BYTES    = 1 << EE_AW;
  localparam EE_PAGE     = 1 << EE_PAGE_AW;
  localparam ENTRY_HOLD_CYC = (`PPI_ENTRY_HOLD_NS + `PPI_CLK_PERIOD_NS - 1) / `PPI_CLK_PERIOD_NS;
  // sequencer states
  localparam [5:0] S_IDLE       = 6'h01;
  localparam [5:0] S_ERASE_MEM  = 6'h02;
  localparam [5:0] S_ERASE_LOCK = 6'h04;
  localparam [5:0] S_FLASH      = 6'h08;
  localparam [5:0] S_EEPROM     = 6'h10;
  localparam [5:0] S_NV_WAIT    = 6'h20;
  function [7:0] pick_byte;
    input [15:0] word;
    input        hi;
    begin
      pick_byte = hi ? word[15:8] : word[7:0];
    end
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and edges
  wire [16:0] pins_s;
  ppi_sync #(.W(17)) u_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in ({hv_reset_detect, load_clock, action_code_bit1, action_code_bit0, byte_select_hi,
                byte_select_lo, page_load_strobe, program_strobe_n, output_enable_n, data_in}),
    .sync_out (pins_s)
  );
  wire       hv_s    = pins_s[16];
  wire       lclk_s  = pins_s[15];
  wire [1:0] act_s   = pins_s[14:13];
  wire [1:0] bs_s    = pins_s[12:11];
  wire       page_load_strobe_s = pins_s[10];
  wire       wr_n_s  = pins_s[9];
  wire       oe_n_s  = pins_s[8];
  wire [7:0] data_s  = pins_s[7:0];
  // delayed {hv, wr_n, page_load_strobe, lclk}; zero like the synchroniser, so no false edge after reset
  reg [3:0] pin_d_reg;
  always @(posedge clk) begin
    if (reset)
      pin_d_reg <= 4'h0;
    else
      pin_d_reg <= {hv_s, wr_n_s, page_load_strobe_s, lclk_s};
  end
  wire lclk_rise  = lclk_s & ~pin_d_reg[0];
  wire lclk_tog   = lclk_s ^ pin_d_reg[0];
  wire page_load_strobe_rise = page_load_strobe_s & ~pin_d_reg[1];
  wire wr_fall    = ~wr_n_s & pin_d_reg[2];
  wire hv_rise    = hv_s & ~pin_d_reg[3];
  wire entry_pat  = ~page_load_strobe_s & (act_s == 2'h0) & ~bs_s[0];
  //////////////////////////////////////////////////////////////////////////////
  // programming mode entry
  reg [2:0] toggle_cnt_reg;
  reg [3:0] hold_cnt_reg;
  reg       entering_reg;
  always @(posedge clk) begin
    if (reset) begin
      toggle_cnt_reg   <= 3'h0;
      hold_cnt_reg     <= 4'h0;
      entering_reg     <= 1'b0;
      prog_mode_active <= 1'b0;
    end else if (!hv_s) begin
      entering_reg     <= 1'b0;
      prog_mode_active <= 1'b0;
      if (lclk_tog && toggle_cnt_reg != 3'h7)
        toggle_cnt_reg <= toggle_cnt_reg + 3'h1; // [RULE_11]
    end else if (hv_rise) begin
      // pattern must already stand when the high voltage arrives
      entering_reg <= entry_pat && toggle_cnt_reg >= `PPI_ENTRY_TOGGLES; // [RULE_10] [RULE_11]
      hold_cnt_reg <= 4'h0;
    end else if (entering_reg) begin
      if (!entry_pat) begin
        entering_reg   <= 1'b0; // [RULE_10]
        toggle_cnt_reg <= 3'h0;
      end else if (hold_cnt_reg == ENTRY_HOLD_CYC[3:0]) begin
        entering_reg     <= 1'b0;
        prog_mode_active <= 1'b1;
        toggle_cnt_reg   <= 3'h0;
      end else begin
        hold_cnt_reg <= hold_cnt_reg + 4'h1;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // command, address and data loading
  reg [7:0] cmd_reg;
  reg [7:0] addr_lo_reg;
  reg [7:0] addr_hi_reg;
  reg [7:0] addr_ext_reg;
  reg [7:0] data_lo_reg;
  reg [7:0] data_hi_reg;
  reg [5:0] state_reg;
  wire busy     = (state_reg != S_IDLE);
  wire load_evt = prog_mode_active & lclk_rise; // [RULE_26]
  wire nop_load = load_evt & (act_s == `PPI_ACT_CMD) & ~busy & (data_s == `PPI_CMD_NOP);
  // retained until overwritten; nothing else clears them
  always @(posedge clk) begin
    if (reset) begin
      cmd_reg      <= `PPI_CMD_NOP;
      addr_lo_reg  <= 8'h00;
      addr_hi_reg  <= 8'h00;
      addr_ext_reg <= 8'h00;
      data_lo_reg  <= 8'hff;
      data_hi_reg  <= 8'hff;
    end else if (load_evt) begin
      case (act_s) // [RULE_02] [RULE_13]
        `PPI_ACT_ADDR: begin
          case (bs_s) // [RULE_05]
            `PPI_BS_LOW:  addr_lo_reg  <= data_s;
            `PPI_BS_HIGH: addr_hi_reg  <= data_s;
            `PPI_BS_EXT:  addr_ext_reg <= data_s;
            default:      addr_lo_reg  <= addr_lo_reg;
          endcase
        end
        `PPI_ACT_DATA: begin
          if (!bs_s[1]) begin // [RULE_06]
            if (bs_s[0])
              data_hi_reg <= data_s;
            else
              data_lo_reg <= data_s;
          end
        end
        `PPI_ACT_CMD: begin
          // a command during an operation is ignored
          if (!busy)
            cmd_reg <= data_s; // [RULE_17]
        end
        default: cmd_reg <= cmd_reg;
      endcase
    end
  end
  wire [23:0]                  addr_full        = {addr_ext_reg, addr_hi_reg, addr_lo_reg};
  wire [FLASH_AW-1:0]          flash_addr       = addr_full[FLASH_AW-1:0];
  // page bits include the top of the low byte when pages are short
  wire [FLASH_AW-PAGE_AW-1:0]  flash_page_index = flash_addr[FLASH_AW-1:PAGE_AW]; // [RULE_19] [RULE_20]
  wire [PAGE_AW-1:0]           flash_word_index = flash_addr[PAGE_AW-1:0]; // [RULE_19]
  wire [EE_AW-1:0]             eeprom_byte_address = addr_full[EE_AW-1:0];
  wire [EE_AW-EE_PAGE_AW-1:0]  ee_page_index = eeprom_byte_address[EE_AW-1:EE_PAGE_AW]; // [RULE_21]
  wire [EE_PAGE_AW-1:0]        ee_byte_index = eeprom_byte_address[EE_PAGE_AW-1:0]; // [RULE_21]
  //////////////////////////////////////////////////////////////////////////////
  // memories, page buffers and the operation sequencer
  reg [15:0] flash_mem [0:FLASH_WORDS-1];
  reg [7:0]  ee_mem    [0:EE_BYTES-1];
  reg [15:0] page_buf  [0:PAGE_WORDS-1];
  reg [7:0]  ee_buf    [0:EE_PAGE-1];
  reg [PAGE_WORDS-1:0] page_valid_reg;
  reg [EE_PAGE-1:0]    ee_valid_reg;
  reg [7:0]          fuse_low_reg;
  reg [7:0]          fuse_high_reg;
  reg [7:0]          fuse_ext_reg;
  reg [7:0]          lock_reg;
  reg [FLASH_AW-1:0] idx_reg;
  reg [7:0]          wait_cnt_reg;
  reg                keep_ee_reg;
  wire wr_start = prog_mode_active & wr_fall & ~busy; // [RULE_03]
  always @(posedge clk) begin
    if (reset) begin
      state_reg      <= S_IDLE;
      idx_reg        <= {FLASH_AW{1'b0}};
      wait_cnt_reg   <= 8'h00;
      keep_ee_reg    <= 1'b0;
      page_valid_reg <= {PAGE_WORDS{1'b0}};
      ee_valid_reg   <= {EE_PAGE{1'b0}};
      fuse_low_reg   <= `PPI_FUSE_LOW_RST;
      fuse_high_reg  <= `PPI_FUSE_HIGH_RST;
      fuse_ext_reg   <= `PPI_FUSE_EXT_RST;
      lock_reg       <= `PPI_LOCK_RST;
    end else begin
      if (nop_load) begin
        page_valid_reg <= {PAGE_WORDS{1'b0}}; // [RULE_24]
        ee_valid_reg   <= {EE_PAGE{1'b0}};
      end
      if (prog_mode_active && page_load_strobe_rise && bs_s[0] && !busy) begin // [RULE_18]
        if (cmd_reg == `PPI_CMD_WR_FLASH) begin
          page_buf[flash_word_index]       <= {data_hi_reg, data_lo_reg};
          page_valid_reg[flash_word_index] <= 1'b1;
        end else if (cmd_reg == `PPI_CMD_WR_EEPROM) begin
          ee_buf[ee_byte_index]       <= data_lo_reg;
          ee_valid_reg[ee_byte_index] <= 1'b1;
        end
      end
      case (state_reg)
        S_IDLE: begin
          idx_reg <= {FLASH_AW{1'b0}};
          if (wr_start) begin
            case (cmd_reg) // [RULE_04]
              `PPI_CMD_CHIP_ERASE: begin
                // keep fuse acts as soon as it is programmed
                keep_ee_reg <= ~fuse_high_reg[`PPI_KEEP_EE_BIT]; // [RULE_16]
                state_reg   <= S_ERASE_MEM; // [RULE_17]
              end
              `PPI_CMD_WR_FUSE: begin
                case (bs_s)
                  `PPI_BS_LOW:  fuse_low_reg  <= data_lo_reg;
                  `PPI_BS_HIGH: fuse_high_reg <= data_lo_reg;
                  `PPI_BS_EXT:  fuse_ext_reg  <= data_lo_reg;
                  default:      fuse_low_reg  <= fuse_low_reg;
                endcase
                wait_cnt_reg <= 8'h00;
                state_reg    <= S_NV_WAIT;
              end
              `PPI_CMD_WR_LOCK: begin
                // lock bits only go to programmed, erase alone clears them
                lock_reg     <= lock_reg & data_lo_reg;
                wait_cnt_reg <= 8'h00;
                state_reg    <= S_NV_WAIT;
              end
              `PPI_CMD_WR_FLASH: begin
                if (bs_s == `PPI_BS_LOW)
                  state_reg <= S_FLASH; // [RULE_23]
              end
              `PPI_CMD_WR_EEPROM: begin
                if (bs_s == `PPI_BS_LOW)
                  state_reg <= S_EEPROM; // [RULE_23]
              end
              default: state_reg <= S_IDLE;
            endcase
          end
        end
        S_ERASE_MEM: begin
          flash_mem[idx_reg] <= 16'hffff; // [RULE_15]
          if (idx_reg < EE_BYTES && !keep_ee_reg)
            ee_mem[idx_reg[EE_AW-1:0]] <= 8'hff; // [RULE_16]
          idx_reg <= idx_reg + {{(FLASH_AW-1){1'b0}}, 1'b1};
          if (&idx_reg)
            state_reg <= S_ERASE_LOCK;
        end
        S_ERASE_LOCK: begin
          // locks drop only after the whole array is blank; fuses untouched
          lock_reg  <= `PPI_LOCK_RST; // [RULE_15]
          state_reg <= S_IDLE;
        end
        S_FLASH: begin
          if (page_valid_reg[idx_reg[PAGE_AW-1:0]])
            flash_mem[{flash_page_index, idx_reg[PAGE_AW-1:0]}] <= page_buf[idx_reg[PAGE_AW-1:0]];
          idx_reg <= idx_reg + {{(FLASH_AW-1){1'b0}}, 1'b1};
          if (&idx_reg[PAGE_AW-1:0]) begin
            page_valid_reg <= {PAGE_WORDS{1'b0}};
            state_reg      <= S_IDLE;
          end
        end
        S_EEPROM: begin
          if (ee_valid_reg[idx_reg[EE_PAGE_AW-1:0]])
            ee_mem[{ee_page_index, idx_reg[EE_PAGE_AW-1:0]}] <= ee_buf[idx_reg[EE_PAGE_AW-1:0]];
          idx_reg <= idx_reg + {{(FLASH_AW-1){1'b0}}, 1'b1};
          if (&idx_reg[EE_PAGE_AW-1:0]) begin
            ee_valid_reg <= {EE_PAGE{1'b0}};
            state_reg    <= S_IDLE;
          end
        end
        S_NV_WAIT: begin
          wait_cnt_reg <= wait_cnt_reg + 8'h01;
          if (wait_cnt_reg == NV_WRITE_CYC[7:0] - 8'h01)
            state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // readback and status pins
  reg [7:0] rd_next;
  always @* begin
    rd_next = 8'hff;
    case (cmd_reg)
      `PPI_CMD_RD_FLASH:  rd_next = pick_byte(flash_mem[flash_addr], bs_s[0]); // [RULE_25]
      `PPI_CMD_RD_EEPROM: rd_next = ee_mem[eeprom_byte_address];
      `PPI_CMD_RD_FUSE: begin
        case (bs_s) // [RULE_07]
          2'h0:    rd_next = fuse_low_reg;
          2'h1:    rd_next = lock_reg;
          2'h2:    rd_next = fuse_ext_reg;
          default: rd_next = fuse_high_reg;
        endcase
      end
      `PPI_CMD_RD_SIG: begin
        if (bs_s[0])
          rd_next = CAL_BYTE;
        else if (addr_lo_reg[1:0] == 2'h0)
          rd_next = SIG_BYTE0;
        else if (addr_lo_reg[1:0] == 2'h1)
          rd_next = SIG_BYTE1;
        else
          rd_next = SIG_BYTE2;
      end
      default: rd_next = 8'hff;
    endcase
  end
  always @(posedge clk) begin
    if (reset) begin
      data_out     <= 8'h00;
      data_oe      <= 1'b0;
      ready_busy_n <= 1'b1;
    end else begin
      data_oe      <= prog_mode_active & ~oe_n_s; // [RULE_09]
      data_out     <= (prog_mode_active & ~oe_n_s) ? rd_next : 8'h00;
      ready_busy_n <= ~(busy | wr_start); // [RULE_08] [RULE_17]
    end
  end
endmodule // ppi_top

/* ppi_top_sva.sv */
// checker for the programming port of ppi_top, bound to its ports
// assumes pins held at least five clocks and a synchronous reset
`timescale 1ns/10ps
module ppi_top_sva (
  // clock and reset
  input wire       clk,
  input wire       reset,
  // pins
  input wire       hv_reset_detect,
  input wire       action_code_bit1,
  input wire       action_code_bit0,
  input wire       byte_select_lo,
  input wire       page_load_strobe,
  input wire       program_strobe_n,
  input wire       output_enable_n,
  // outputs
  input wire [7:0] data_out,
  input wire       data_oe,
  input wire       ready_busy_n,
  input wire       prog_mode_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // longest busy spell is the reduced chip erase, 1026 cycles
  reg [11:0] busy_cnt_reg;
  always @(posedge clk) begin
    if (reset || ready_busy_n)
      busy_cnt_reg <= 12'h000;
    else
      busy_cnt_reg <= busy_cnt_reg + 12'h001;
  end
  sequence s_oe_off;
    output_enable_n [*5];
  endsequence
  sequence s_hv_off;
    !hv_reset_detect [*4];
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  a_reset_outputs: assert property ($fell(reset) |-> ready_busy_n && !data_oe && !prog_mode_active)
    else $error("outputs wrong after reset");
  a_oe_idle_off: assert property (s_oe_off |-> !data_oe)
    else $error("bus driven without read enable");
  a_out_idle_zero: assert property (!data_oe |-> data_out == 8'h00)
    else $error("data out not zero while released");
  a_oe_drive_on: assert property ($fell(output_enable_n) && prog_mode_active |-> ##[2:5] data_oe)
    else $error("bus not driven on read");
  a_busy_cause: assert property ($fell(ready_busy_n) |-> !$past(program_strobe_n) && prog_mode_active)
    else $error("busy without write strobe");
  a_busy_bound: assert property (busy_cnt_reg <= 12'h406)
    else $error("busy too long");
  a_entry_pattern: assert property ($rose(prog_mode_active) |-> $past(hv_reset_detect, 2)
    && !$past(page_load_strobe, 2) && !$past(action_code_bit1, 2) && !$past(action_code_bit0, 2)
    && !$past(byte_select_lo, 2))
    else $error("entry without pattern");
  a_exit_mode: assert property (s_hv_off |-> !prog_mode_active)
    else $error("mode without high voltage");
endmodule // ppi_top_sva

bind ppi_top ppi_top_sva u_sva (
  .clk, .reset, .hv_reset_detect, .action_code_bit1, .action_code_bit0, .byte_select_lo,
  .page_load_strobe, .program_strobe_n, .output_enable_n, .data_out, .data_oe, .ready_busy_n,
  .prog_mode_active
);

/* ppi_prog_model.sv */
// programmer model: drives the programming pins and the data bus
// assumes its tasks are called from the bench at a falling clock edge
`timescale 1ns/10ps
module ppi_prog_model (
  // clock
  input  wire       clk,
  // control pins
  output reg        hv_reset_detect,
  output reg        load_clock,
  output reg        action_code_bit1,
  output reg        action_code_bit0,
  output reg        byte_select_hi,
  output reg        byte_select_lo,
  output reg        page_load_strobe,
  output reg        program_strobe_n,
  output reg        output_enable_n,
  // data bus
  output wire [7:0] data_in,
  input  wire [7:0] data_out,
  input  wire       data_oe
);
  reg [7:0] bus_reg;
  reg       drive_reg;
  // released bus shows the inverse of the last byte so stale data never matches
  assign data_in = data_oe ? data_out : (drive_reg ? bus_reg : ~bus_reg);
  initial begin
    {hv_reset_detect, load_clock, page_load_strobe} = 3'h0;
    {action_code_bit1, action_code_bit0, byte_select_hi, byte_select_lo} = 4'hc;
    {program_strobe_n, output_enable_n, drive_reg} = 3'h7;
    bus_reg = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////////
  task ticks(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task enter;
    begin
      repeat (6) begin
        load_clock = 1'b1;
        ticks(5);
        load_clock = 1'b0;
        ticks(3);
      end
      {page_load_strobe, action_code_bit1, action_code_bit0, byte_select_lo} = 4'h0;
      ticks(3);
      hv_reset_detect = 1'b1;
      ticks(1000); // settling, pattern held meanwhile
    end
  endtask
  task ld(input [1:0] act, input [1:0] bs, input [7:0] val);
    begin
      ticks(2);
      {action_code_bit1, action_code_bit0} = act;
      {byte_select_hi, byte_select_lo} = bs;
      bus_reg = val;
      ticks(1);
      load_clock = 1'b1;
      ticks(5);
      load_clock = 1'b0;
    end
  endtask
  task pulse_pl;
    begin
      ticks(1);
      byte_select_lo = 1'b1;
      ticks(1);
      page_load_strobe = 1'b1;
      ticks(5);
      page_load_strobe = 1'b0;
    end
  endtask
  task pulse_wr(input [1:0] bs);
    begin
      ticks(1);
      {byte_select_hi, byte_select_lo} = bs;
      ticks(1);
      program_strobe_n = 1'b0;
      ticks(5);
      program_strobe_n = 1'b1;
    end
  endtask
  task read(input [1:0] bs, output [7:0] val, output on, output off);
    begin
      ticks(1);
      {byte_select_hi, byte_select_lo} = bs;
      drive_reg = 1'b0;
      output_enable_n = 1'b0;
      ticks(6);
      val = data_in;
      on = data_oe;
      output_enable_n = 1'b1;
      ticks(5);
      off = data_oe;
      drive_reg = 1'b1;
    end
  endtask
  task leave;
    begin
      hv_reset_detect = 1'b0;
      ticks(5);
    end
  endtask
endmodule // ppi_prog_model

/* ppi_top_tb.sv */
// testbench for ppi_top driven through the programmer model
// assumes reduced flash and eeprom sizes and short fuse write time
`timescale 1ns/10ps
`include "ppi_defines.vh"
module ppi_top_tb;
  localparam [7:0] SIG0 = 8'h4b; // arbitrary identity value
  localparam [7:0] SIG1 = 8'h6c; // arbitrary identity value
  localparam [7:0] SIG2 = 8'h2d; // arbitrary identity value
  localparam [7:0] CAL  = 8'h3a; // arbitrary calibration value
  reg        clk = 1'b0;
  reg        reset = 1'b1;
  wire       hv_reset_detect, load_clock, action_code_bit1, action_code_bit0;
  wire       byte_select_hi, byte_select_lo, page_load_strobe, program_strobe_n, output_enable_n;
  wire [7:0] data_in;
  wire [7:0] data_out;
  wire       data_oe, ready_busy_n, prog_mode_active;
  integer    bad_count = 0;
  integer    num_checks = 0;
  reg  [7:0] rd_val;
  reg        oe_on, oe_off;
  always #25 clk = ~clk;
  ppi_prog_model u_prog (.clk, .hv_reset_detect, .load_clock, .action_code_bit1, .action_code_bit0,
    .byte_select_hi, .byte_select_lo, .page_load_strobe, .program_strobe_n, .output_enable_n,
    .data_in, .data_out, .data_oe);
  ppi_top #(.FLASH_AW(10), .EE_AW(8), .NV_WRITE_CYC(4), .SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1),
    .SIG_BYTE2(SIG2), .CAL_BYTE(CAL)) dut (.clk, .reset, .hv_reset_detect, .load_clock,
    .action_code_bit1, .action_code_bit0, .byte_select_hi, .byte_select_lo, .page_load_strobe,
    .program_strobe_n, .output_enable_n, .data_in, .data_out, .data_oe, .ready_busy_n, .prog_mode_active);
  //////////////////////////////////////////////////////////////////////////////
  task check(input [7:0] got, input [7:0] exp, input string msg);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
      end
    end
  endtask
  task cmd(input [7:0] c);
    u_prog.ld(2'h2, 2'h0, c);
  endtask
  task adr(input [1:0] bs, input [7:0] v);
    u_prog.ld(2'h0, bs, v);
  endtask
  task dat(input [7:0] lo, input [7:0] hi);
    begin
      u_prog.ld(2'h1, 2'h0, lo);
      u_prog.ld(2'h1, 2'h1, hi);
    end
  endtask
  task rd_chk(input [1:0] bs, input [7:0] exp, input string msg);
    begin
      u_prog.read(bs, rd_val, oe_on, oe_off);
      check(rd_val, exp, msg);
      check({7'h00, oe_on}, 8'h01, "drive on read");
      check({7'h00, oe_off}, 8'h00, "release after read");
    end
  endtask
  task page_write(input [1:0] bs, input integer len);
    integer n;
    begin
      u_prog.pulse_wr(bs);
      check({7'h00, ready_busy_n}, 8'h00, "busy after strobe");
      n = 0;
      while (ready_busy_n !== 1'b1 && n < len + 10) begin
        @(negedge clk);
        n = n + 1;
      end
      check({7'h00, (n + 2 >= len) && (n <= len)}, 8'h01, "busy length");
    end
  endtask
  task vfy(input er);
    begin
      cmd(`PPI_CMD_RD_FLASH);
      adr(2'h0, 8'h85);
      rd_chk(2'h0, er ? 8'hff : 8'h34, "flash low");
      rd_chk(2'h1, er ? 8'hff : 8'h12, "flash high");
      adr(2'h0, 8'h86);
      rd_chk(2'h0, er ? 8'hff : 8'h78, "second word");
      adr(2'h0, 8'h05);
      rd_chk(2'h0, 8'hff, "other page");
      cmd(`PPI_CMD_RD_EEPROM);
      adr(2'h0, 8'h0a);
      rd_chk(2'h0, 8'h5c, "eeprom");
      cmd(`PPI_CMD_RD_FUSE);
      rd_chk(2'h1, er ? 8'hff : 8'hfc, "lock");
      rd_chk(2'h3, 8'h91, "fuse high");
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task t_entry;
    begin
      check({7'h00, prog_mode_active}, 8'h00, "mode before entry");
      u_prog.enter;
      check({7'h00, prog_mode_active}, 8'h01, "mode after entry");
      check({7'h00, ready_busy_n}, 8'h01, "ready after entry");
      $display("test entry done");
    end
  endtask
  task t_ids;
    integer i;
    begin
      cmd(`PPI_CMD_RD_FUSE);
      rd_chk(2'h0, `PPI_FUSE_LOW_RST, "fuse low");
      rd_chk(2'h1, `PPI_LOCK_RST, "lock");
      rd_chk(2'h2, `PPI_FUSE_EXT_RST, "fuse ext");
      rd_chk(2'h3, `PPI_FUSE_HIGH_RST, "fuse high");
      cmd(`PPI_CMD_RD_SIG);
      for (i = 0; i < 3; i = i + 1) begin
        adr(2'h0, i[7:0]);
        rd_chk(2'h0, i == 0 ? SIG0 : (i == 1 ? SIG1 : SIG2), "signature");
      end
      adr(2'h3, 8'h00); // reserved select must not load
      u_prog.ld(2'h3, 2'h0, `PPI_CMD_RD_FLASH); // idle code must not load
      rd_chk(2'h0, SIG2, "reserved select");
      rd_chk(2'h1, CAL, "calibration");
      $display("test ids done");
    end
  endtask
  task t_program;
    begin
      cmd(`PPI_CMD_CHIP_ERASE);
      page_write(2'h0, 1025);
      cmd(`PPI_CMD_WR_FLASH);
      adr(2'h1, 8'h00);
      adr(2'h0, 8'h85);
      dat(8'h34, 8'h12);
      u_prog.ld(2'h1, 2'h2, 8'hee);
      u_prog.pulse_pl;
      adr(2'h0, 8'h86);
      dat(8'h78, 8'h56);
      u_prog.pulse_pl;
      page_write(2'h0, 128);
      adr(2'h0, 8'h05);
      dat(8'haa, 8'hbb);
      u_prog.pulse_pl;
      cmd(`PPI_CMD_NOP);
      cmd(`PPI_CMD_WR_FLASH);
      page_write(2'h0, 128);
      cmd(`PPI_CMD_WR_EEPROM);
      adr(2'h0, 8'h0a);
      u_prog.ld(2'h1, 2'h0, 8'h5c);
      u_prog.pulse_pl;
      page_write(2'h0, 8);
      cmd(`PPI_CMD_WR_FUSE);
      u_prog.ld(2'h1, 2'h0, 8'h91);
      page_write(2'h1, 4); // keep-eeprom bit programmed
      cmd(`PPI_CMD_WR_LOCK);
      u_prog.ld(2'h1, 2'h0, 8'hfc);
      page_write(2'h0, 4);
      vfy(1'b0);
      cmd(`PPI_CMD_CHIP_ERASE);
      page_write(2'h0, 1025);
      vfy(1'b1);
      $display("test program done");
    end
  endtask
  task t_exit;
    begin
      u_prog.leave;
      check({7'h00, prog_mode_active}, 8'h00, "mode after exit");
      u_prog.read(2'h0, rd_val, oe_on, oe_off);
      check({7'h00, oe_on}, 8'h00, "drive outside mode");
      $display("test exit done");
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(negedge clk);
    reset = 1'b0;
    t_entry;
    t_ids;
    t_program;
    t_exit;
    report_and_stop;
  end
  // run needs about 4100 clocks; allow over four times that
  initial begin
    #1000000;
    bad_count = bad_count + 1;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop;
  end
endmodule // ppi_top_tb
